// ==== pkg/iiu_regs.vh ====
`ifndef IIU_REGS_VH
`define IIU_REGS_VH
// register offsets on the device register port
`define IIU_ADDR_W 8
`define IIU_OFF_ENABLE 8'h0B
`define IIU_OFF_EVENTS 8'h0C
`define IIU_OFF_LIVE 8'h0D
// reset values
`define IIU_ENABLE_RST 16'h4000
`define IIU_EVENTS_RST 16'h0000
// bit positions
`define IIU_BIT_SAMPLE 15
`define IIU_BIT_RESET_COMPLETE 14
`define IIU_BIT_BUSY 13
`define IIU_BIT_COOL 11
`define IIU_BIT_THERM 10
`define IIU_BIT_LINK 9
`define IIU_BIT_CFGMM 8
`define IIU_BIT_WARNC 3
`define IIU_BIT_WARNB 2
`define IIU_BIT_WARNA 1
`define IIU_BIT_BOUT 0
// field masks
`define IIU_ENABLE_MASK 16'hEF0F
`define IIU_EVENT_MASK 16'h6F0F
`define IIU_LOW_MASK 16'h7FFF
`define IIU_EDGE_SET_MASK 16'h400F
`define IIU_LEVEL_SET_MASK 16'h2F00
`define IIU_ZERO16 16'h0000
// sample timing
`define IIU_SAMPLE_PERIOD_NS 10000
`define IIU_CLK_PERIOD_NS 10
`endif

// ==== design/iiu_edge.v ====
`timescale 1ns/10ps
`default_nettype none
module iiu_edge #(
	parameter W = 16
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	input wire ce,
	// raw levels and results
	input wire [W-1:0] din,
	output wire [W-1:0] lvl,
	output wire [W-1:0] rise
);
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1)
		begin : g_bit
			reg meta_ff;
			reg sync_ff;
			reg prev_ff;
			// first stage feeds only the second
			always @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					meta_ff <= 1'b0;
					sync_ff <= 1'b0;
					prev_ff <= 1'b0;
				end
				else if (ce)
				begin
					meta_ff <= din[i];
					sync_ff <= meta_ff;
					prev_ff <= sync_ff;
				end
			end
			assign lvl[i] = sync_ff;
			assign rise[i] = sync_ff & ~prev_ff;
		end
	endgenerate
endmodule
`default_nettype wire

// ==== design/iiu_top.v ====
`timescale 1ns/10ps
`default_nettype none
`include "iiu_regs.vh"
module iiu_top #(
	parameter CLK_PERIOD_NS = `IIU_CLK_PERIOD_NS,
	parameter SAMPLE_PERIOD_NS = `IIU_SAMPLE_PERIOD_NS
) (
	// clock, reset, enable
	input wire CORE_CLK,
	input wire RSTN,
	input wire CE,
	// register port
	input wire [`IIU_ADDR_W-1:0] REG_ADDR,
	input wire REG_WR,
	input wire REG_RD,
	input wire [15:0] REG_WDATA,
	output wire [15:0] REG_RDATA,
	input wire CFG_LOCK,
	// event sources
	input wire RESET_DONE,
	input wire LINK_BUSY,
	input wire COOLING,
	input wire THERMAL_OFF,
	input wire LINK_ERR,
	input wire CFG_MISMATCH,
	input wire WARN_A,
	input wire WARN_B,
	input wire WARN_C,
	input wire BINARY_OUT,
	// outputs
	output wire IRQ_N,
	output wire SAMPLE_STROBE,
	output wire LINK_RESEND
);
	// sample period in clock cycles, rounded down
	localparam SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
	// width caps the period at 8192 cycles; widen for faster clocks
	localparam CNT_W = 13;
	localparam integer SAMPLE_LAST_I = SAMPLE_CYCLES - 1;
	localparam [CNT_W-1:0] SAMPLE_LAST = SAMPLE_LAST_I[CNT_W-1:0];
	localparam [CNT_W-1:0] CNT_ZERO = 13'h0000;
	localparam [CNT_W-1:0] CNT_ONE = 13'h0001;

	function reg_hit;
		input [`IIU_ADDR_W-1:0] addr;
		input [`IIU_ADDR_W-1:0] off;
		begin
			reg_hit = (addr == off);
		end
	endfunction

	// reset release synchroniser
	// asserts at once, releases only on a clock edge
	reg rst_meta_ff;
	reg rst_sync_ff;
	always @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end
	wire rst_n = rst_sync_ff;

	// source vector in register layout
	reg [15:0] src_raw;
	always @*
	begin
		src_raw = `IIU_ZERO16;
		src_raw[`IIU_BIT_RESET_COMPLETE] = RESET_DONE;
		src_raw[`IIU_BIT_BUSY] = LINK_BUSY;
		src_raw[`IIU_BIT_COOL] = COOLING;
		src_raw[`IIU_BIT_THERM] = THERMAL_OFF;
		src_raw[`IIU_BIT_LINK] = LINK_ERR;
		src_raw[`IIU_BIT_CFGMM] = CFG_MISMATCH;
		src_raw[`IIU_BIT_WARNC] = WARN_C;
		src_raw[`IIU_BIT_WARNB] = WARN_B;
		src_raw[`IIU_BIT_WARNA] = WARN_A;
		src_raw[`IIU_BIT_BOUT] = BINARY_OUT;
	end

	// sources come from the isolated side, so synchronise first
	wire [15:0] src_lvl;
	wire [15:0] src_rise;
	iiu_edge #(
		.W(16)
	) u_edge (
		.clk(CORE_CLK),
		.rst_n(rst_n),
		.ce(CE),
		.din(src_raw),
		.lvl(src_lvl),
		.rise(src_rise)
	);

	wire [15:0] set_edge = src_rise & `IIU_EDGE_SET_MASK;
	wire [15:0] set_level = src_lvl & `IIU_LEVEL_SET_MASK;
	// reset done rides the edge mask
	wire [15:0] ev_set = set_edge | set_level;

	// register access decode
	wire hit_enable = reg_hit(REG_ADDR, `IIU_OFF_ENABLE);
	wire hit_events = reg_hit(REG_ADDR, `IIU_OFF_EVENTS);
	wire hit_live = reg_hit(REG_ADDR, `IIU_OFF_LIVE);

	// enable register
	reg [15:0] enable_ff;
	reg [15:0] nxt_enable;
	always @*
	begin
		nxt_enable = enable_ff;
		// lock protects configuration, not acknowledgement
		if (REG_WR && hit_enable && !CFG_LOCK)
			nxt_enable = REG_WDATA & `IIU_ENABLE_MASK;
	end
	always @(posedge CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
			enable_ff <= `IIU_ENABLE_RST;
		else if (CE)
			enable_ff <= nxt_enable;
	end

	// event register
	// reserved bits masked so they can never latch
	reg [15:0] events_ff;
	reg [15:0] nxt_events;
	reg [15:0] ev_clr;
	always @*
	begin
		ev_clr = `IIU_ZERO16;
		if (REG_WR && hit_events)
			ev_clr = REG_WDATA;
		nxt_events = ((events_ff & ~ev_clr) | ev_set) & `IIU_EVENT_MASK;
	end
	always @(posedge CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
			events_ff <= `IIU_EVENTS_RST;
		else if (CE)
			events_ff <= nxt_events;
	end

	// resend request on each new link error
	reg resend_ff;
	always @(posedge CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
			resend_ff <= 1'b0;
		else if (CE)
			resend_ff <= src_rise[`IIU_BIT_LINK];
	end
	assign LINK_RESEND = resend_ff;

	reg [CNT_W-1:0] tick_cnt_ff;
	reg [CNT_W-1:0] nxt_tick_cnt;
	reg sample_ff;
	wire tick_wrap = (tick_cnt_ff == SAMPLE_LAST);
	always @*
	begin
		if (tick_wrap)
			nxt_tick_cnt = CNT_ZERO;
		else
			nxt_tick_cnt = tick_cnt_ff + CNT_ONE;
	end
	always @(posedge CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_cnt_ff <= CNT_ZERO;
			sample_ff <= 1'b0;
		end
		else if (CE)
		begin
			tick_cnt_ff <= nxt_tick_cnt;
			sample_ff <= tick_wrap;
		end
	end
	assign SAMPLE_STROBE = sample_ff;

	// interrupt source selection
	// pin is registered so it cannot glitch while events settle
	wire sample_mode = enable_ff[`IIU_BIT_SAMPLE];
	wire latched_irq = |(enable_ff & events_ff & `IIU_LOW_MASK);
	reg irq_ff;
	reg nxt_irq;
	always @*
	begin
		// other enables assumed zero, so ignored
		if (sample_mode)
			nxt_irq = tick_wrap;
		else
			nxt_irq = latched_irq;
	end
	always @(posedge CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
			irq_ff <= 1'b0;
		else if (CE)
			irq_ff <= nxt_irq;
	end
	assign IRQ_N = ~irq_ff;

	// read data, registered
	reg [15:0] rdata_ff;
	reg [15:0] nxt_rdata;
	always @*
	begin
		nxt_rdata = rdata_ff;
		if (REG_RD)
		begin
			if (hit_enable)
				nxt_rdata = enable_ff;
			else if (hit_events)
				nxt_rdata = events_ff;
			else if (hit_live)
				nxt_rdata = src_lvl & `IIU_EVENT_MASK;
			else
				nxt_rdata = `IIU_ZERO16;
		end
	end
	always @(posedge CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
			rdata_ff <= `IIU_ZERO16;
		else if (CE)
			rdata_ff <= nxt_rdata;
	end
	assign REG_RDATA = rdata_ff;
endmodule
`default_nettype wire

// ==== tb/iiu_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module iiu_props (
	// watched ports
	input wire logic CORE_CLK,
	input wire logic RSTN,
	input wire logic CE,
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [15:0] REG_WDATA,
	input wire logic [15:0] REG_RDATA,
	input wire logic CFG_LOCK,
	input wire logic LINK_ERR,
	input wire logic IRQ_N,
	input wire logic SAMPLE_STROBE,
	input wire logic LINK_RESEND
);
	logic smode_ff;
	logic nxt_smode;
	logic rd_ok;
	default clocking @(posedge CORE_CLK);
	endclocking
	// a frozen block is not judged
	default disable iff (!RSTN || !CE);
	assign rd_ok = CE && REG_RD;
	// locked writes leave the mode alone
	assign nxt_smode = (CE && REG_WR && !CFG_LOCK && REG_ADDR == 8'h0B) ? REG_WDATA[15] : smode_ff;
	always_ff @(posedge CORE_CLK or negedge RSTN)
		if (!RSTN)
			smode_ff <= 1'b0;
		else
			smode_ff <= nxt_smode;
	a_rdata_hold: assert property (!rd_ok |=> $stable(REG_RDATA))
		else $error("rdata moved");
	a_unmapped_zero: assert property (rd_ok && REG_ADDR != 8'h0B && REG_ADDR != 8'h0C && REG_ADDR != 8'h0D
		|=> REG_RDATA == 16'h0000) else $error("unmapped nonzero");
	a_event_rsvd: assert property (rd_ok && REG_ADDR == 8'h0C |=> (REG_RDATA & 16'h90F0) == 16'h0000)
		else $error("event reserved set");
	a_enable_rsvd: assert property (rd_ok && REG_ADDR == 8'h0B |=> (REG_RDATA & 16'h10F0) == 16'h0000)
		else $error("enable reserved set");
	a_strobe_gap: assert property (SAMPLE_STROBE |=> !SAMPLE_STROBE [*8]) else $error("strobe too close");
	a_resend_rise: assert property ($rose(LINK_ERR) && CE |-> ##[1:5] LINK_RESEND) else $error("no resend");
	a_resend_pulse: assert property (LINK_RESEND |=> !LINK_RESEND) else $error("resend long");
	a_sample_irq: assert property (smode_ff && $past(smode_ff) |-> IRQ_N == !SAMPLE_STROBE)
		else $error("irq off sample");
endmodule
bind iiu_top iiu_props u_props (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .CE(CE), .REG_ADDR(REG_ADDR),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .CFG_LOCK(CFG_LOCK),
	.LINK_ERR(LINK_ERR), .IRQ_N(IRQ_N), .SAMPLE_STROBE(SAMPLE_STROBE), .LINK_RESEND(LINK_RESEND));
`default_nettype wire

// ==== tb/iiu_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module iiu_host (
	// register port
	input wire logic clk,
	output logic [7:0] addr,
	output logic wr,
	output logic rd,
	output logic [15:0] wdata,
	input wire logic [15:0] rdata
);
	initial
	begin
		addr = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		wdata = 16'h0000;
	end
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		// released data never shows stale value
		wdata <= ~d;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
endmodule
`default_nettype wire

// ==== tb/isolated_input_interrupt_unit_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module isolated_input_interrupt_unit_tb_top;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic lock = 1'b0;
	logic ce = 1'b1;
	logic [15:0] lv = 16'h0000;
	logic [15:0] en;
	logic [15:0] ev;
	logic [15:0] got;
	logic [15:0] w;
	logic [7:0] addr;
	logic wr;
	logic rd;
	logic [15:0] wdata;
	wire logic [15:0] rdata;
	wire logic irq_n;
	integer n_mismatch = 0;
	integer n_tests = 0;
	integer cnt;
	always #5 clk = ~clk;
	iiu_top #(.SAMPLE_PERIOD_NS(200)) dut_u (.CORE_CLK(clk), .RSTN(rstn), .CE(ce), .REG_ADDR(addr),
		.REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .CFG_LOCK(lock), .RESET_DONE(lv[14]),
		.LINK_BUSY(lv[13]), .COOLING(lv[11]), .THERMAL_OFF(lv[10]), .LINK_ERR(lv[9]), .CFG_MISMATCH(lv[8]),
		.WARN_A(lv[1]), .WARN_B(lv[2]), .WARN_C(lv[3]), .BINARY_OUT(lv[0]), .IRQ_N(irq_n),
		.SAMPLE_STROBE(), .LINK_RESEND());
	iiu_host h (.clk(clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_tests = n_tests + 1;
		if (g !== e)
		begin
			n_mismatch = n_mismatch + 1;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic stop_test();
		if (n_mismatch == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		n_mismatch = n_mismatch + 1;
		stop_test();
	end
	initial
	begin
		void'($urandom(32'h36E1));
		en = 16'h4000;
		ev = 16'h0000;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		h.rd_reg(8'h0B, got);
		chk(got, en);
		h.rd_reg(8'h0C, got);
		chk(got, ev);
		h.rd_reg(8'h0E, got);
		chk(got, 16'h0000);
		repeat (40)
		begin
			w = 16'($urandom) & 16'h6F0F;
			// edge bits on rise, levels while high
			ev = ev | (w & ~lv & 16'h400F) | (w & 16'h2F00);
			@(posedge clk);
			lv <= w;
			repeat (5) @(posedge clk);
			h.rd_reg(8'h0C, got);
			chk(got, ev);
			h.rd_reg(8'h0D, got);
			chk(got, lv);
			@(posedge clk);
			lock <= 1'($urandom);
			w = 16'($urandom) & 16'h7FFF;
			h.wr_reg(8'h0B, w);
			if (!lock)
				en = w & 16'h6F0F;
			w = 16'($urandom);
			h.wr_reg(8'h0C, w);
			// clears work while locked; set wins
			ev = (ev & ~w) | (lv & 16'h2F00);
			h.rd_reg(8'h0B, got);
			chk(got, en);
			h.rd_reg(8'h0C, got);
			chk(got, ev);
			if (ev[9])
				h.wr_reg(8'h0B, en);
			chk({15'h0, irq_n}, {15'h0, ~|(en & ev)});
		end
		@(posedge clk);
		lock <= 1'b0;
		// clock enable low: the write must not land
		ce <= 1'b0;
		h.wr_reg(8'h0B, 16'h8F0F);
		ce <= 1'b1;
		h.rd_reg(8'h0B, got);
		chk(got, en);
		h.wr_reg(8'h0B, 16'h8000);
		repeat (3) @(posedge clk);
		cnt = 0;
		repeat (40)
		begin
			@(negedge clk);
			cnt = cnt + !irq_n;
		end
		chk(16'(cnt), 16'h0002);
		stop_test();
	end
endmodule
`default_nettype wire
